// ==== rtl/smcfg_calc.sv ====
// Combinational derivation of synthesizer word, decimation and rate step.
// Assumes stored fields and receive mode come from logic on the same clock.
`timescale 1ns/1ps
`include "smcfg_defs.svh"

module smcfg_calc
    import smcfg_pkg::*;
(
    input  wire smcfg_cfg_t     cfg_i,
    input  wire logic           rx_mode_i,
    output smcfg_derived_t      drv_o
);

    // Widen an unsigned field and shift it into base-word units
    function automatic logic [`SMCFG_WORD_W-1:0] scale_up(input logic [7:0] v,
                                                          input logic [4:0] sh);
        logic [`SMCFG_WORD_W-1:0] w;
        w = {16'h0000, v};
        scale_up = w << sh;
    endfunction

    logic [`SMCFG_WORD_W-1:0] off_units;
    logic [`SMCFG_WORD_W-1:0] if_units;
    logic [`SMCFG_WORD_W-1:0] if_sub;
    logic [`SMCFG_WORD_W-1:0] rate_man9;
    logic [`SMCFG_DECIM_W-1:0] bw_div;

    // Offset steps are four base steps; sign extension keeps it two's complement
    assign off_units = {{(`SMCFG_WORD_W-8){cfg_i.synth_offset[7]}}, cfg_i.synth_offset}
                       << `SMCFG_OFF_SHIFT;
    // IF steps are 64 base steps
    assign if_units  = scale_up({3'h0, cfg_i.if_setting}, 5'(`SMCFG_IF_SHIFT));
    assign if_sub    = rx_mode_i ? if_units : '0;

    // Wraps modulo 2^24, same as the synthesizer accumulator
    assign drv_o.synth_word = cfg_i.base_word + off_units - if_sub;

    // 8*(4+m)*2^e, at most 448
    assign bw_div = {6'h00, (`SMCFG_BW_BASE + {1'b0, cfg_i.bandwidth_mantissa})}
                    << `SMCFG_BW_SCALE;
    assign drv_o.decim_ratio = bw_div << cfg_i.bandwidth_exponent;

    // Hidden ninth mantissa bit, then 2^e; the 2^28 divisor is left to the NCO
    assign rate_man9 = {15'h0000, `SMCFG_RATE_HIDDEN, cfg_i.rate_mantissa};
    assign drv_o.rate_step = rate_man9 << cfg_i.rate_exponent;

endmodule

// ==== rtl/smcfg_defs.svh ====
// Constants for the synthesizer and modem configuration register bank.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef SMCFG_DEFS_SVH
`define SMCFG_DEFS_SVH

// Register access port widths
`define SMCFG_AW              6
`define SMCFG_DW              8

// Register offsets
`define SMCFG_ADDR_IF_CTRL    6'h0B
`define SMCFG_ADDR_OFFSET     6'h0C
`define SMCFG_ADDR_BASE_WORD_HI    6'h0D
`define SMCFG_ADDR_BASE_WORD_MID   6'h0E
`define SMCFG_ADDR_BASE_WORD_LO    6'h0F
`define SMCFG_ADDR_BW_RATE    6'h10
`define SMCFG_ADDR_RATE_MAN   6'h11

// Reset values
`define SMCFG_RST_IF          5'h0F
`define SMCFG_RST_IF_SPARE    1'h0
`define SMCFG_RST_OFFSET      8'h00
`define SMCFG_RST_BASE_WORD_HI     6'h1E
`define SMCFG_RST_BASE_WORD_MID    8'hC4
`define SMCFG_RST_BASE_WORD_LO     8'hEC
`define SMCFG_RST_BW_E        2'h2
`define SMCFG_RST_BW_M        2'h0
`define SMCFG_RST_RATE_E      4'hC
`define SMCFG_RST_RATE_M      8'h22

// Field positions
`define SMCFG_IF_MSB          4
`define SMCFG_IF_LSB          0
`define SMCFG_IF_SPARE_BIT    5
`define SMCFG_BASE_WORD_HI_MSB     5
`define SMCFG_BASE_WORD_HI_LSB     0
`define SMCFG_BW_E_MSB        7
`define SMCFG_BW_E_LSB        6
`define SMCFG_BW_M_MSB        5
`define SMCFG_BW_M_LSB        4
`define SMCFG_RATE_E_MSB      3
`define SMCFG_RATE_E_LSB      0

// Derived value widths and scaling
`define SMCFG_WORD_W          24
`define SMCFG_DECIM_W         9
`define SMCFG_OFF_SHIFT       2
`define SMCFG_IF_SHIFT        6
`define SMCFG_BW_BASE         3'h4
`define SMCFG_BW_SCALE        3
`define SMCFG_RATE_HIDDEN     1'h1

`endif

// ==== rtl/smcfg_defs_unused_placeholder.sv ====
// Spare slot among the register bank sources; it holds no logic.
// Assumes nothing of its surroundings and may be left out of a build.

// ==== rtl/smcfg_pkg.sv ====
// Types shared by the configuration register bank and its derivation logic.
// Assumes the constants header is on the include path.
`include "smcfg_defs.svh"

package smcfg_pkg;

    // One register access from the serial interface engine
    typedef struct packed {
        logic                   wr;
        logic                   rd;
        logic [`SMCFG_AW-1:0]   addr;
        logic [`SMCFG_DW-1:0]   wdata;
    } smcfg_req_t;

    // Stored fields as seen by synthesizer and modem
    typedef struct packed {
        logic [4:0]             if_setting;
        logic [7:0]             synth_offset;
        logic [`SMCFG_WORD_W-1:0] base_word;
        logic [1:0]             bandwidth_exponent;
        logic [1:0]             bandwidth_mantissa;
        logic [3:0]             rate_exponent;
        logic [7:0]             rate_mantissa;
    } smcfg_cfg_t;

    // Values derived from the stored fields
    typedef struct packed {
        logic [`SMCFG_WORD_W-1:0]  synth_word;
        logic [`SMCFG_DECIM_W-1:0] decim_ratio;
        logic [`SMCFG_WORD_W-1:0]  rate_step;
    } smcfg_derived_t;

endpackage

// ==== rtl/smcfg_regs.sv ====
// Synthesizer and modem configuration register bank, with derived outputs.
// Assumes the serial interface engine runs on core_clk_i and presents one
// register access per cycle; receive mode comes from the same clock domain.
//
// How it works
// - Five-bit IF field, reset fifteen
// - Signed offset added to base word
// - Top two frequency bits read zero
// - Three bytes form 24-bit base word
// - Bandwidth exponent and mantissa set decimation
// - Four-bit rate exponent, reset twelve
// - Rate mantissa with hidden ninth bit
`timescale 1ns/1ps
`include "smcfg_defs.svh"

module smcfg_regs
    import smcfg_pkg::*;
(
    input  wire logic                    core_clk_i,
    input  wire logic                    sys_rst_i,
    input  wire logic                    ce_i,
    input  wire smcfg_req_t              req_i,
    input  wire logic                    rx_mode_i,
    output logic [`SMCFG_DW-1:0]         rdata_o,
    output logic                         rdata_valid_o,
    output logic                         if_spare_o,
    output smcfg_cfg_t                   cfg_o,
    output smcfg_derived_t               drv_o
);

    // Stored fields
    logic [4:0]              if_setting_r;
    logic [4:0]              if_setting_nxt;
    logic                    if_spare_r;
    logic                    if_spare_nxt;
    logic [7:0]              synth_offset_r;
    logic [7:0]              synth_offset_nxt;
    logic [5:0]              base_word_hi_r;
    logic [5:0]              base_word_hi_nxt;
    logic [7:0]              base_word_mid_r;
    logic [7:0]              base_word_mid_nxt;
    logic [7:0]              base_word_lo_r;
    logic [7:0]              base_word_lo_nxt;
    logic [1:0]              bw_exp_r;
    logic [1:0]              bw_exp_nxt;
    logic [1:0]              bw_man_r;
    logic [1:0]              bw_man_nxt;
    logic [3:0]              rate_exp_r;
    logic [3:0]              rate_exp_nxt;
    logic [7:0]              rate_man_r;
    logic [7:0]              rate_man_nxt;

    // Read side
    logic [`SMCFG_DW-1:0]    rdata_r;
    logic [`SMCFG_DW-1:0]    rdata_nxt;
    logic                    rvalid_r;

    // Output copies
    smcfg_cfg_t              cfg_now;
    smcfg_cfg_t              cfg_r;
    smcfg_derived_t          drv_now;
    smcfg_derived_t          drv_r;

    // Address decode
    logic                    hit_if;
    logic                    hit_off;
    logic                    hit_hi;
    logic                    hit_mid;
    logic                    hit_lo;
    logic                    hit_bw;
    logic                    hit_rate;
    logic                    sel_if;
    logic                    sel_off;
    logic                    sel_hi;
    logic                    sel_mid;
    logic                    sel_lo;
    logic                    sel_bw;
    logic                    sel_rate;
    logic [`SMCFG_DW-1:0]    wd;

    // Compare a request address against a register offset
    function automatic logic addr_is(input logic [`SMCFG_AW-1:0] a,
                                     input logic [`SMCFG_AW-1:0] reg_off);
        addr_is = (a == reg_off);
    endfunction

    // Offset match, shared so write and read decode can never disagree
    assign sel_if   = addr_is(req_i.addr, `SMCFG_ADDR_IF_CTRL);
    assign sel_off  = addr_is(req_i.addr, `SMCFG_ADDR_OFFSET);
    assign sel_hi   = addr_is(req_i.addr, `SMCFG_ADDR_BASE_WORD_HI);
    assign sel_mid  = addr_is(req_i.addr, `SMCFG_ADDR_BASE_WORD_MID);
    assign sel_lo   = addr_is(req_i.addr, `SMCFG_ADDR_BASE_WORD_LO);
    assign sel_bw   = addr_is(req_i.addr, `SMCFG_ADDR_BW_RATE);
    assign sel_rate = addr_is(req_i.addr, `SMCFG_ADDR_RATE_MAN);

    // Write strobes per register, one access at a time
    assign wd       = req_i.wdata;
    assign hit_if   = req_i.wr && sel_if;
    assign hit_off  = req_i.wr && sel_off;
    assign hit_hi   = req_i.wr && sel_hi;
    assign hit_mid  = req_i.wr && sel_mid;
    assign hit_lo   = req_i.wr && sel_lo;
    assign hit_bw   = req_i.wr && sel_bw;
    assign hit_rate = req_i.wr && sel_rate;

    // Next values; fields not addressed keep their contents
    assign if_setting_nxt   = hit_if ? wd[`SMCFG_IF_MSB:`SMCFG_IF_LSB]
                                     : if_setting_r;
    assign if_spare_nxt     = hit_if ? wd[`SMCFG_IF_SPARE_BIT] : if_spare_r;
    assign synth_offset_nxt = hit_off ? wd : synth_offset_r;
    // Bits 7:6 of the high byte have no storage, so writes there vanish
    assign base_word_hi_nxt      = hit_hi ? wd[`SMCFG_BASE_WORD_HI_MSB:`SMCFG_BASE_WORD_HI_LSB]
                                     : base_word_hi_r;
    assign base_word_mid_nxt     = hit_mid ? wd : base_word_mid_r;
    assign base_word_lo_nxt      = hit_lo ? wd : base_word_lo_r;
    assign bw_exp_nxt       = hit_bw ? wd[`SMCFG_BW_E_MSB:`SMCFG_BW_E_LSB]
                                     : bw_exp_r;
    assign bw_man_nxt       = hit_bw ? wd[`SMCFG_BW_M_MSB:`SMCFG_BW_M_LSB]
                                     : bw_man_r;
    assign rate_exp_nxt     = hit_bw ? wd[`SMCFG_RATE_E_MSB:`SMCFG_RATE_E_LSB]
                                     : rate_exp_r;
    assign rate_man_nxt     = hit_rate ? wd : rate_man_r;

    // Field storage; reset brings the documented power-up configuration
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            if_setting_r   <= `SMCFG_RST_IF;
            if_spare_r     <= `SMCFG_RST_IF_SPARE;
            synth_offset_r <= `SMCFG_RST_OFFSET;
            base_word_hi_r      <= `SMCFG_RST_BASE_WORD_HI;
            base_word_mid_r     <= `SMCFG_RST_BASE_WORD_MID;
            base_word_lo_r      <= `SMCFG_RST_BASE_WORD_LO;
            bw_exp_r       <= `SMCFG_RST_BW_E;
            bw_man_r       <= `SMCFG_RST_BW_M;
            rate_exp_r     <= `SMCFG_RST_RATE_E;
            rate_man_r     <= `SMCFG_RST_RATE_M;
        end else if (ce_i) begin
            if_setting_r   <= if_setting_nxt;
            if_spare_r     <= if_spare_nxt;
            synth_offset_r <= synth_offset_nxt;
            base_word_hi_r      <= base_word_hi_nxt;
            base_word_mid_r     <= base_word_mid_nxt;
            base_word_lo_r      <= base_word_lo_nxt;
            bw_exp_r       <= bw_exp_nxt;
            bw_man_r       <= bw_man_nxt;
            rate_exp_r     <= rate_exp_nxt;
            rate_man_r     <= rate_man_nxt;
        end
    end

    // Read mux; unmapped offsets and unused bits read as zero
    always_comb begin
        rdata_nxt = '0;
        if (sel_if) begin
            rdata_nxt = {2'b00, if_spare_r, if_setting_r};
        end else if (sel_off) begin
            rdata_nxt = synth_offset_r;
        end else if (sel_hi) begin
            rdata_nxt = {2'b00, base_word_hi_r};
        end else if (sel_mid) begin
            rdata_nxt = base_word_mid_r;
        end else if (sel_lo) begin
            rdata_nxt = base_word_lo_r;
        end else if (sel_bw) begin
            rdata_nxt = {bw_exp_r, bw_man_r, rate_exp_r};
        end else if (sel_rate) begin
            rdata_nxt = rate_man_r;
        end
    end

    // Read data is captured so the serial engine sees a stable byte
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rdata_r  <= '0;
            rvalid_r <= 1'b0;
        end else if (ce_i) begin
            rvalid_r <= req_i.rd;
            if (req_i.rd) begin
                rdata_r <= rdata_nxt;
            end
        end
    end

    // Assemble stored fields for the consumers
    assign cfg_now.if_setting         = if_setting_r;
    assign cfg_now.synth_offset       = synth_offset_r;
    assign cfg_now.base_word          = {2'b00, base_word_hi_r, base_word_mid_r, base_word_lo_r};
    assign cfg_now.bandwidth_exponent = bw_exp_r;
    assign cfg_now.bandwidth_mantissa = bw_man_r;
    assign cfg_now.rate_exponent      = rate_exp_r;
    assign cfg_now.rate_mantissa      = rate_man_r;

    // Derived synthesizer, decimation and rate values
    smcfg_calc u_calc (
        .cfg_i     (cfg_now),
        .rx_mode_i (rx_mode_i),
        .drv_o     (drv_now)
    );

    // Output stage; one cycle of latency keeps the adder off the output path
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cfg_r.if_setting         <= `SMCFG_RST_IF;
            cfg_r.synth_offset       <= `SMCFG_RST_OFFSET;
            cfg_r.base_word          <= {2'b00, `SMCFG_RST_BASE_WORD_HI,
                                         `SMCFG_RST_BASE_WORD_MID, `SMCFG_RST_BASE_WORD_LO};
            cfg_r.bandwidth_exponent <= `SMCFG_RST_BW_E;
            cfg_r.bandwidth_mantissa <= `SMCFG_RST_BW_M;
            cfg_r.rate_exponent      <= `SMCFG_RST_RATE_E;
            cfg_r.rate_mantissa      <= `SMCFG_RST_RATE_M;
            drv_r                    <= '0;
        end else if (ce_i) begin
            cfg_r <= cfg_now;
            drv_r <= drv_now;
        end
    end

    // Ports straight from flops
    assign rdata_o       = rdata_r;
    assign rdata_valid_o = rvalid_r;
    assign if_spare_o    = if_spare_r;
    assign cfg_o         = cfg_r;
    assign drv_o         = drv_r;

endmodule

// ==== verification/smcfg_host_model.sv ====
// Host side of the register port: one access at a time, driven at falling edges.
// Assumes it shares core_clk_i with the register bank.
`timescale 1ns/1ps
module smcfg_host_model
    import smcfg_pkg::*;
(
    input  wire logic       core_clk_i,
    input  wire logic [7:0] rdata_i,
    input  wire logic       rdata_valid_i,
    output smcfg_req_t      req_o
);
    initial req_o = '0;

    // Idle bus shows inverted values so a stale address never looks held
    task automatic access(input logic w, input logic [5:0] a, input logic [7:0] d,
                          output logic [7:0] q, output logic v);
        @(negedge core_clk_i);
        req_o = {w, !w, a, d};
        @(negedge core_clk_i);
        q = rdata_i;
        v = rdata_valid_i;
        req_o = {2'h0, ~a, ~d};
    endtask
endmodule

// ==== verification/smcfg_regs_chk.sv ====
// Checker for the configuration register bank, bound to its top module.
// Assumes one clock domain and the asynchronous reset of the design.
`timescale 1ns/1ps
`include "smcfg_defs.svh"
module smcfg_regs_chk
    import smcfg_pkg::*;
(
    input wire logic                core_clk_i,
    input wire logic                sys_rst_i,
    input wire logic                ce_i,
    input wire smcfg_req_t          req_i,
    input wire logic                rx_mode_i,
    input wire logic [`SMCFG_DW-1:0] rdata_o,
    input wire logic                rdata_valid_o,
    input wire logic                if_spare_o,
    input wire smcfg_cfg_t          cfg_o,
    input wire smcfg_derived_t      drv_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);

    // Accepted requests and expected synthesizer terms
    wire        rd_tk    = ce_i && req_i.rd;
    wire        wr_tk    = ce_i && req_i.wr;
    wire        unmap    = req_i.addr < 6'h0B || req_i.addr > 6'h11;
    wire [23:0] base_off = cfg_o.base_word
                         + {{14{cfg_o.synth_offset[7]}}, cfg_o.synth_offset, 2'h0};
    wire [23:0] if_term  = {13'h0, cfg_o.if_setting, 6'h00};

    a_read_answer: assert property (rd_tk |=> rdata_valid_o)
        else $error("read not answered");
    a_valid_single: assert property (ce_i && !req_i.rd |=> !rdata_valid_o)
        else $error("valid without read");
    a_top_bits_zero: assert property ($past(rd_tk && (req_i.addr == 6'h0B ||
        req_i.addr == 6'h0D)) |-> rdata_o[7:6] == 2'h0) else $error("dead bits read set");
    a_unmapped_zero: assert property ($past(rd_tk && unmap) |-> rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_word_top_zero: assert property (cfg_o.base_word[23:22] == 2'h0)
        else $error("base word top bits set");
    a_synth_word: assert property (!$past(sys_rst_i) && $past(ce_i) |->
        drv_o.synth_word == base_off - ($past(rx_mode_i) ? if_term : 24'h0))
        else $error("synth word wrong");
    a_decim_ratio: assert property (!$past(sys_rst_i) |-> drv_o.decim_ratio ==
        (9'h4 + 9'(cfg_o.bandwidth_mantissa)) << (cfg_o.bandwidth_exponent + 3))
        else $error("decimation wrong");
    a_rate_step: assert property (!$past(sys_rst_i) |-> drv_o.rate_step ==
        (24'h100 + 24'(cfg_o.rate_mantissa)) << cfg_o.rate_exponent) else $error("rate wrong");
    a_write_lands: assert property (wr_tk && req_i.addr == 6'h0E ##1
        (ce_i && !(req_i.wr && req_i.addr == 6'h0E)) |=>
        cfg_o.base_word[15:8] == $past(req_i.wdata, 2)) else $error("write lost");
    a_cfg_holds: assert property (ce_i && !req_i.wr |-> ##2 $stable(cfg_o))
        else $error("field changed unwritten");
    a_rdata_holds: assert property (!rd_tk |=> $stable(rdata_o))
        else $error("read data moved");
    a_frozen_hold: assert property (!ce_i |=> $stable(cfg_o) && $stable(drv_o) &&
        $stable(rdata_o) && $stable(rdata_valid_o)) else $error("state moved while frozen");

    // Main scenarios reached
    c_read: cover property (rd_tk ##1 rdata_valid_o);
    c_rx_on: cover property ($rose(rx_mode_i));
    c_hi_write: cover property (wr_tk && req_i.addr == 6'h0D);
    c_frozen: cover property (!ce_i && req_i.wr);
endmodule

bind smcfg_regs smcfg_regs_chk u_chk (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
    .ce_i(ce_i), .req_i(req_i), .rx_mode_i(rx_mode_i), .rdata_o(rdata_o),
    .rdata_valid_o(rdata_valid_o), .if_spare_o(if_spare_o), .cfg_o(cfg_o), .drv_o(drv_o));

// ==== verification/tb_smcfg_regs.sv ====
// Self-checking bench for the configuration register bank.
// Assumes the host model drives requests and the checker binds itself.
`timescale 1ns/1ps
module tb_smcfg_regs;
    import smcfg_pkg::*;
    logic           core_clk_i  = 1'b0;
    logic           sys_rst_i   = 1'b1;
    logic           ce_i        = 1'b1;
    logic           rx_mode_i   = 1'b0;
    smcfg_req_t     req;
    logic [7:0]     rdata;
    logic           rvalid;
    logic           spare;
    smcfg_cfg_t     cfg;
    smcfg_derived_t drv;
    logic [7:0]     mem [0:63];
    logic [7:0]     q;
    logic           v;
    int             miscompares = 0;
    int             comparisons = 0;
    int             cycles      = 0;

    always #4 core_clk_i = ~core_clk_i;

    smcfg_regs uut (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i), .req_i(req),
        .rx_mode_i(rx_mode_i), .rdata_o(rdata), .rdata_valid_o(rvalid), .if_spare_o(spare),
        .cfg_o(cfg), .drv_o(drv));
    smcfg_host_model host (.core_clk_i(core_clk_i), .rdata_i(rdata), .rdata_valid_i(rvalid),
        .req_o(req));

    // Dead top bits and unmapped places drop writes
    function automatic logic [7:0] wmask(input logic [5:0] ad);
        if (ad == 6'h0B || ad == 6'h0D) return 8'h3F;
        return (ad >= 6'h0B && ad <= 6'h11) ? 8'hFF : 8'h00;
    endfunction
    function automatic logic [23:0] exp_synth(input logic rx);
        return {mem[13], mem[14], mem[15]} + {{14{mem[12][7]}}, mem[12], 2'h0}
            - (rx ? {13'h0, mem[11][4:0], 6'h00} : 24'h0);
    endfunction

    // Power-up contents, also used after a reset in mid-run
    task automatic mem_reset;
        mem = '{default: 8'h00};
        mem[11] = 8'h0F;
        mem[13] = 8'h1E;
        mem[14] = 8'hC4;
        mem[15] = 8'hEC;
        mem[16] = 8'h8C;
        mem[17] = 8'h22;
    endtask
    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rd_chk(input logic [5:0] ad);
        host.access(1'b0, ad, 8'h00, q, v);
        chk("read valid", 24'h1, {23'h0, v});
        chk("read data", {16'h0, mem[ad]}, {16'h0, q});
    endtask
    task automatic wr(input logic [5:0] ad, input logic [7:0] d);
        host.access(1'b1, ad, d, q, v);
        if (ce_i) mem[ad] = d & wmask(ad);
    endtask
    task automatic all_chk;
        chk("base word", {mem[13], mem[14], mem[15]}, cfg.base_word);
        chk("if and offset", {11'h0, mem[11][4:0], mem[12]},
            {11'h0, cfg.if_setting, cfg.synth_offset});
        chk("modem fields", {8'h0, mem[16], mem[17]},
            {8'h0, cfg.bandwidth_exponent, cfg.bandwidth_mantissa, cfg.rate_exponent,
             cfg.rate_mantissa});
        chk("synth word", exp_synth(rx_mode_i), drv.synth_word);
        chk("decimation", 24'((9'h4 + 9'(mem[16][5:4])) << (mem[16][7:6] + 3)),
            24'(drv.decim_ratio));
        chk("rate step", (24'h100 + 24'(mem[17])) << mem[16][3:0], drv.rate_step);
        chk("spare bit", 24'(mem[11][5]), 24'(spare));
    endtask
    task automatic stop_test;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Hang guard, well above the few hundred cycles needed
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            stop_test();
        end
    end

    initial begin
        void'($urandom(32'hC16662B9));
        mem_reset();
        repeat (5) @(negedge core_clk_i);
        sys_rst_i = 1'b0;
        @(negedge core_clk_i);
        all_chk();
        // Reset values, unmapped neighbours included
        for (int r = 8; r < 20; r++) begin
            rd_chk(6'(r));
        end
        wr(6'h0B, 8'hFF);
        wr(6'h0D, 8'hFF);
        rd_chk(6'h0B);
        rd_chk(6'h0D);
        // Most negative offset while receiving
        rx_mode_i = 1'b1;
        wr(6'h0C, 8'h80);
        rd_chk(6'h0C);
        all_chk();
        // Frozen clock enable drops the write
        ce_i = 1'b0;
        wr(6'h0F, 8'h5A);
        ce_i = 1'b1;
        rd_chk(6'h0F);
        repeat (80) begin
            rx_mode_i = 1'($urandom);
            wr(6'h08 + 6'($urandom % 12), 8'($urandom));
            rd_chk(6'h08 + 6'($urandom % 12));
            all_chk();
        end
        // Reset in mid-run brings the power-up fields back
        sys_rst_i = 1'b1;
        repeat (2) @(negedge core_clk_i);
        sys_rst_i = 1'b0;
        mem_reset();
        @(negedge core_clk_i);
        all_chk();
        rd_chk(6'h0B);
        rd_chk(6'h0D);
        stop_test();
    end
endmodule
